//--- hw/dmg_guard.sv
// dmg_guard: interrupt, write guard and end pin control of a two channel dma
// assumes apb3 master on pclk; dtc_master marks transfers from the data
// transfer controller; transfer datapath drives the done and cycle inputs
//
// Overview of operation
// [R1] ch1 xfer enable falling with end irq enable set raises end irq
// [R2] ch0 xfer enable falling with end irq enable set raises end irq
// [R3] handler cancels end irq by clearing enable or re-enabling transfer
// [R4] ch0 master enable falling with break irq enable set raises break irq
// [R5] handler cancels ch0 break irq by clearing enable or setting master
// [R6] interrupt enable bits 3..0 are read/write and reset to zero
// [R7] guard bits 7..4 and terminal bits 7,6,3..0 read zero, ignore writes
// [R8] guard bit 3 opens half 1b control, bits 11,7,3 and terminal bit 5
// [R9] guard bit 2 opens half 1a control and bits 10,6,2
// [R10] guard bit 1 opens half 0b control, bits 9,5,1 and terminal bit 4
// [R11] guard bit 0 opens half 0a control and bits 8,4,0
// [R12] guard restrictions apply to writes from the data transfer controller
// [R13] controller writes to address mode bits 15..12 are always ignored
// [R14] controller may set enable bits 7..4 without reading zero first
// [R15] reactivating full address channel needs both a and b guard bits
// [R16] address and count registers always accept writes
// [R17] software halts a channel before changing its address registers
// [R18] controller sets guard so other channels stay masked
// [R19] terminal bits 5 and 4 enable end pins, port switched to output
// [R20] end pin works only for the b half in short address mode
// [R21] outside block mode end pin asserts when transfer counter hits zero
// [R22] in block mode end pin asserts when block counter hits zero
// [R23] xfer enable clears on reset, completion, or software writing zero
// [R24] channel acts on requests only with xfer and master enable both set
// [R25] ch1 master enable falling with break irq enable set raises break irq
// [R26] guarded bits hold on a blocked write, unguarded bits still update
// [R27] each irq request holds until its cancel condition occurs
`timescale 1ns/10ps
`default_nettype none
module dmg_guard #(
    parameter int MEM_ADDR_W = 24,
    parameter int IO_ADDR_W  = 16,
    parameter int COUNT_W    = 16,
    parameter int HALF_W     = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        dtc_master,
    input  wire logic [1:0]  xfer_done,
    input  wire logic [1:0]  block_mode,
    input  wire logic [1:0]  count_zero_cycle,
    input  wire logic [1:0]  block_zero_cycle,
    output logic      [1:0]  chan_active,
    output logic      [1:0]  end_irq_req,
    output logic      [1:0]  break_irq_req,
    output logic      [1:0]  end_pin,
    output logic      [1:0]  end_pin_oe_n
);
    logic [15:0]         chan_ff, nxt_chan;
    logic [7:0]          guard_ff, nxt_guard;
    logic [7:0]          term_ff, nxt_term;
    logic [15:0]         armed_ff, nxt_armed;
    logic [HALF_W-1:0]   half_ff [4];
    logic [HALF_W-1:0]   nxt_half [4];
    logic [MEM_ADDR_W-1:0] mem_ff [2];
    logic [MEM_ADDR_W-1:0] nxt_mem [2];
    logic [IO_ADDR_W-1:0]  io_ff [2];
    logic [IO_ADDR_W-1:0]  nxt_io [2];
    logic [COUNT_W-1:0]    cnt_ff [2];
    logic [COUNT_W-1:0]    nxt_cnt [2];
    logic [31:0]         rdata_ff, nxt_rdata;
    logic                err_ff, nxt_err;
    logic [1:0]          end_irq_ff, nxt_end_irq;
    logic [1:0]          brk_irq_ff, nxt_brk_irq;
    logic [1:0]          pin_ff, nxt_pin;
    logic                wr_go, rd_go, setup;
    logic [15:0]         bcr_open;
    logic [1:0]          xfer_en, master_en, end_en, brk_en;

    assign setup  = psel & ~penable;
    assign wr_go  = psel & penable & pwrite;
    assign rd_go  = psel & penable & ~pwrite;
    assign pready = 1'b1; // zero wait states
    assign prdata = rdata_ff;
    assign pslverr = psel & penable & err_ff;

    // per channel views of the enable control register
    assign xfer_en   = {chan_ff[dmg_pkg::BIT_XFER_ENABLE_CH1],
                        chan_ff[dmg_pkg::BIT_XFER_ENABLE_CH0]};
    assign master_en = {chan_ff[dmg_pkg::BIT_MASTER_EN_CH1],
                        chan_ff[dmg_pkg::BIT_MASTER_EN_CH0]};
    assign end_en    = {chan_ff[dmg_pkg::BIT_END_IRQ_EN_CH1],
                        chan_ff[dmg_pkg::BIT_END_IRQ_EN_CH0]};
    assign brk_en    = {chan_ff[dmg_pkg::BIT_BREAK_IRQ_EN_CH1],
                        chan_ff[dmg_pkg::BIT_BREAK_IRQ_EN_CH0]};
    assign chan_active = xfer_en & master_en; // R24

    // which control bits a write may touch: bit n belongs to half n mod 4
    always_comb begin
        for (int b = 0; b < 16; b++) begin
            bcr_open[b] = ~dtc_master | guard_ff[b % 4]; // R8 R9 R10 R11 R12
        end
        if (dtc_master) begin
            bcr_open = bcr_open & ~dmg_pkg::DTC_LOCK_MASK; // R13
        end
    end

    // read mux, decoded in setup so prdata comes from a flip-flop
    always_comb begin
        logic [7:0] rel;
        rel       = 8'h00;
        nxt_rdata = rdata_ff;
        nxt_err   = err_ff;
        if (setup) begin
            nxt_rdata = 32'h0000_0000;
            nxt_err   = 1'b0;
            rel       = paddr - dmg_pkg::OFS_ADDR_BASE;
            if (paddr[1:0] != 2'b00) begin
                nxt_err = 1'b1;
            end else if (paddr == dmg_pkg::OFS_CHAN_CTRL) begin
                nxt_rdata[15:0] = chan_ff;
            end else if (paddr == dmg_pkg::OFS_WRITE_GUARD) begin
                nxt_rdata[7:0] = guard_ff; // R7
            end else if (paddr == dmg_pkg::OFS_TERM_CTRL) begin
                nxt_rdata[7:0] = term_ff; // R7
            end else if (paddr == dmg_pkg::OFS_STATUS) begin
                nxt_rdata[5:0] = {chan_active, brk_irq_ff, end_irq_ff};
            end else if (paddr[7:4] == dmg_pkg::OFS_HALF_BASE[7:4]) begin
                nxt_rdata[HALF_W-1:0] = half_ff[paddr[3:2]];
            end else if (paddr >= dmg_pkg::OFS_ADDR_BASE
                         && rel < 2 * dmg_pkg::OFS_ADDR_STRIDE
                         && rel[3:0] != 4'hC) begin
                unique case (rel[3:0])
                    dmg_pkg::OFS_MEM_ADDR[3:0]:
                        nxt_rdata[MEM_ADDR_W-1:0] = mem_ff[rel[4]];
                    dmg_pkg::OFS_IO_ADDR[3:0]:
                        nxt_rdata[IO_ADDR_W-1:0] = io_ff[rel[4]];
                    default:
                        nxt_rdata[COUNT_W-1:0] = cnt_ff[rel[4]];
                endcase
            end else begin
                nxt_err = 1'b1;
            end
        end
    end

    // register writes; completion clears the transfer enable bit
    always_comb begin
        logic [15:0] wv;
        logic [7:0]  rel;
        wv        = pwdata[15:0];
        rel       = paddr - dmg_pkg::OFS_ADDR_BASE;
        nxt_chan  = chan_ff;
        nxt_guard = guard_ff;
        nxt_term  = term_ff;
        nxt_armed = armed_ff;
        nxt_half  = half_ff;
        nxt_mem   = mem_ff;
        nxt_io    = io_ff;
        nxt_cnt   = cnt_ff;
        // a cpu read that sees an enable bit at 0 arms it for setting
        if (rd_go && paddr == dmg_pkg::OFS_CHAN_CTRL) begin
            nxt_armed = ~chan_ff & dmg_pkg::ARMED_MASK;
        end
        if (wr_go && !err_ff) begin
            if (paddr == dmg_pkg::OFS_CHAN_CTRL) begin
                for (int b = 0; b < 16; b++) begin
                    if (bcr_open[b]) begin // R26
                        if (dmg_pkg::ARMED_MASK[b] && wv[b]
                            && !chan_ff[b]) begin
                            // cpu needs the read-zero first
                            nxt_chan[b] = dtc_master | armed_ff[b]; // R14
                        end else begin
                            nxt_chan[b] = wv[b]; // R6 R23
                        end
                    end
                end
            end else if (paddr == dmg_pkg::OFS_WRITE_GUARD) begin
                nxt_guard = pwdata[7:0] & dmg_pkg::GUARD_MASK; // R7
            end else if (paddr == dmg_pkg::OFS_TERM_CTRL) begin
                if (~dtc_master | guard_ff[3]) begin // R8
                    nxt_term[dmg_pkg::BIT_END_PIN_EN_CH1] =
                        pwdata[dmg_pkg::BIT_END_PIN_EN_CH1];
                end
                if (~dtc_master | guard_ff[1]) begin // R10
                    nxt_term[dmg_pkg::BIT_END_PIN_EN_CH0] =
                        pwdata[dmg_pkg::BIT_END_PIN_EN_CH0];
                end
            end else if (paddr[7:4] == dmg_pkg::OFS_HALF_BASE[7:4]) begin
                if (~dtc_master | guard_ff[paddr[3:2]]) begin // R8 R9 R10 R11
                    nxt_half[paddr[3:2]] = pwdata[HALF_W-1:0];
                end
            end else if (paddr >= dmg_pkg::OFS_ADDR_BASE) begin
                // never guarded; software must halt the channel first
                unique case (rel[3:0])
                    dmg_pkg::OFS_MEM_ADDR[3:0]:
                        nxt_mem[rel[4]] = pwdata[MEM_ADDR_W-1:0]; // R16
                    dmg_pkg::OFS_IO_ADDR[3:0]:
                        nxt_io[rel[4]] = pwdata[IO_ADDR_W-1:0]; // R16
                    default:
                        nxt_cnt[rel[4]] = pwdata[COUNT_W-1:0]; // R16
                endcase
            end
        end
        // completion wins over a concurrent write of 1
        if (xfer_done[0]) begin
            nxt_chan[dmg_pkg::BIT_XFER_ENABLE_CH0] = 1'b0; // R23
        end
        if (xfer_done[1]) begin
            nxt_chan[dmg_pkg::BIT_XFER_ENABLE_CH1] = 1'b0; // R23
        end
    end

    // per channel interrupt and end pin logic
    generate
        for (genvar c = 0; c < 2; c++) begin : g_chan
            logic end_fall, brk_fall, b_short;
            assign end_fall = xfer_en[c] & ~nxt_chan[4 + 2 * c];
            assign brk_fall = master_en[c] & ~nxt_chan[5 + 2 * c];
            assign b_short  = chan_ff[12 + c] & ~chan_ff[14 + c];
            always_comb begin
                // sticky request; cancelled by enable off or restart
                nxt_end_irq[c] = end_irq_ff[c];
                if (!end_en[c] || xfer_en[c]) begin
                    nxt_end_irq[c] = 1'b0; // R3 R27
                end
                if (end_fall && nxt_chan[2 * c]) begin
                    nxt_end_irq[c] = 1'b1; // R1 R2
                end
                nxt_brk_irq[c] = brk_irq_ff[c];
                if (!brk_en[c] || master_en[c]) begin
                    nxt_brk_irq[c] = 1'b0; // R5 R27
                end
                if (brk_fall && nxt_chan[1 + 2 * c]) begin
                    nxt_brk_irq[c] = 1'b1; // R4 R25
                end
                // pin is registered: it pulses for one cycle, the cycle after the one whose counter reaches zero
                nxt_pin[c] = term_ff[4 + c] & b_short // R19 R20
                           & (block_mode[c] ? block_zero_cycle[c] // R22
                                            : count_zero_cycle[c]); // R21
            end
        end
    endgenerate

    assign end_irq_req   = end_irq_ff;
    assign break_irq_req = brk_irq_ff;
    assign end_pin       = pin_ff;
    assign end_pin_oe_n  = ~term_ff[5:4]; // R19

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_ff    <= dmg_pkg::RST_CHAN_CTRL; // R6 R23
            guard_ff   <= dmg_pkg::RST_GUARD;
            term_ff    <= dmg_pkg::RST_TERM;
            armed_ff   <= 16'h0000;
            rdata_ff   <= 32'h0000_0000;
            err_ff     <= 1'b0;
            end_irq_ff <= 2'b00;
            brk_irq_ff <= 2'b00;
            pin_ff     <= 2'b00;
            for (int i = 0; i < 4; i++) begin
                half_ff[i] <= '0;
            end
            for (int i = 0; i < 2; i++) begin
                mem_ff[i] <= '0;
                io_ff[i]  <= '0;
                cnt_ff[i] <= '0;
            end
        end else begin
            chan_ff    <= nxt_chan;
            guard_ff   <= nxt_guard;
            term_ff    <= nxt_term;
            armed_ff   <= nxt_armed;
            rdata_ff   <= nxt_rdata;
            err_ff     <= nxt_err;
            end_irq_ff <= nxt_end_irq;
            brk_irq_ff <= nxt_brk_irq;
            pin_ff     <= nxt_pin;
            half_ff    <= nxt_half;
            mem_ff     <= nxt_mem;
            io_ff      <= nxt_io;
            cnt_ff     <= nxt_cnt;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_end_irq_rise: assert property ( // R2
        $fell(xfer_en[0]) && end_en[0] |-> end_irq_req[0])
        else $error("ch0 end irq missing after enable fell");
    a_end_irq_ch1: assert property ( // R1
        $fell(xfer_en[1]) && end_en[1] |-> end_irq_req[1])
        else $error("ch1 end irq missing after enable fell");
    a_brk_irq_ch0: assert property ( // R4
        $fell(master_en[0]) && brk_en[0] |-> break_irq_req[0])
        else $error("ch0 break irq missing");
    a_brk_irq_ch1: assert property ( // R25
        $fell(master_en[1]) && brk_en[1] |-> break_irq_req[1])
        else $error("ch1 break irq missing");
    a_irq_hold: assert property ( // R27
        end_irq_req[0] && end_en[0] && !xfer_en[0] |=> end_irq_req[0])
        else $error("end irq dropped without cancel");
    a_irq_cancel: assert property ( // R3
        end_irq_req[1] && !end_en[1] |=> !end_irq_req[1])
        else $error("end irq not cancelled");
    a_guard_lock: assert property ( // R11
        wr_go && dtc_master && !guard_ff[0]
        && paddr == dmg_pkg::OFS_HALF_BASE |=> $stable(half_ff[0]))
        else $error("guarded half control changed");
    a_mode_lock: assert property ( // R13
        wr_go && dtc_master && paddr == dmg_pkg::OFS_CHAN_CTRL
        |=> $stable(chan_ff[15:12]))
        else $error("controller changed address mode bits");
    a_reserved_zero: assert property ( // R7
        guard_ff[7:4] == 4'h0 && term_ff[7:6] == 2'b00
        && term_ff[3:0] == 4'h0)
        else $error("reserved bits not zero");
    a_done_clears: assert property ( // R23
        xfer_done[0] |=> !xfer_en[0] && !chan_active[0])
        else $error("completion did not clear enable");
    a_pin_off: assert property ( // R20
        !chan_ff[dmg_pkg::BIT_SHORT_ADDR_CH0] |=> !end_pin[0])
        else $error("end pin outside short address b half");
    a_active_both: assert property ( // R24
        $rose(chan_active[1]) |-> $past(wr_go)
        && $past(paddr) == dmg_pkg::OFS_CHAN_CTRL)
        else $error("channel became active without a control write");

    // guard, arming, break cancel and count checks; only controller writes are ever guarded, only cpu sets of bits 7..4 need arming,
    // so the guard and arming antecedents name dtc_master on purpose
    a_brk_cancel: assert property ( // R5
        break_irq_req[0] && master_en[0] |=> !break_irq_req[0])
        else $error("break irq not cancelled by restart");
    a_term_guard: assert property ( // R10
        wr_go && dtc_master && !guard_ff[1]
        && paddr == dmg_pkg::OFS_TERM_CTRL
        |=> $stable(term_ff[dmg_pkg::BIT_END_PIN_EN_CH0]))
        else $error("guarded terminal bit changed");
    a_dtc_arm: assert property ( // R14
        wr_go && !err_ff && dtc_master && guard_ff[0] && !xfer_done[0]
        && paddr == dmg_pkg::OFS_CHAN_CTRL
        && pwdata[dmg_pkg::BIT_XFER_ENABLE_CH0]
        |=> xfer_en[0])
        else $error("controller could not set transfer enable");
    a_blocked_bit: assert property ( // R26
        wr_go && dtc_master && !guard_ff[2]
        && paddr == dmg_pkg::OFS_CHAN_CTRL
        |=> $stable(chan_ff[10]) && $stable(chan_ff[2]))
        else $error("guarded control bit changed");
    a_count_always: assert property ( // R16
        wr_go && !err_ff && paddr == dmg_pkg::OFS_ADDR_BASE
        + dmg_pkg::OFS_ADDR_STRIDE + dmg_pkg::OFS_COUNT
        |=> cnt_ff[1] == $past(pwdata[COUNT_W-1:0]))
        else $error("count register write was lost");

    // main scenarios that the directed bench is expected to reach
    c_end_irq: cover property ($rose(end_irq_req[0]));
    c_brk_irq: cover property ($rose(break_irq_req[1]));
    c_dtc_set: cover property (wr_go && dtc_master && guard_ff[0]);
    c_pin: cover property (end_pin[1]);
    c_term_dtc: cover property (wr_go && dtc_master
        && paddr == dmg_pkg::OFS_TERM_CTRL);
endmodule : dmg_guard
`default_nettype wire

//--- pkg/dmg_pkg.sv
// dmg_pkg: offsets, field positions and reset values of the dma guard block
// assumes a 32-bit apb slave with byte addresses on word boundaries
package dmg_pkg;
    // apb byte offsets
    localparam logic [7:0] OFS_CHAN_CTRL   = 8'h00;
    localparam logic [7:0] OFS_WRITE_GUARD = 8'h04;
    localparam logic [7:0] OFS_TERM_CTRL   = 8'h08;
    localparam logic [7:0] OFS_STATUS      = 8'h0C;
    localparam logic [7:0] OFS_HALF_BASE   = 8'h10; // 0a, 0b, 1a, 1b
    localparam logic [7:0] OFS_ADDR_BASE   = 8'h40; // per channel block
    localparam logic [7:0] OFS_ADDR_STRIDE = 8'h10;
    localparam logic [7:0] OFS_MEM_ADDR    = 8'h00;
    localparam logic [7:0] OFS_IO_ADDR     = 8'h04;
    localparam logic [7:0] OFS_COUNT       = 8'h08;
    // channel enable control field positions
    localparam int BIT_END_IRQ_EN_CH0   = 0;
    localparam int BIT_BREAK_IRQ_EN_CH0 = 1;
    localparam int BIT_END_IRQ_EN_CH1   = 2;
    localparam int BIT_BREAK_IRQ_EN_CH1 = 3;
    localparam int BIT_XFER_ENABLE_CH0  = 4;
    localparam int BIT_MASTER_EN_CH0    = 5;
    localparam int BIT_XFER_ENABLE_CH1  = 6;
    localparam int BIT_MASTER_EN_CH1    = 7;
    localparam int BIT_SHORT_ADDR_CH0   = 12;
    localparam int BIT_SHORT_ADDR_CH1   = 13;
    localparam int BIT_FULL_ADDR_CH0    = 14;
    localparam int BIT_FULL_ADDR_CH1    = 15;
    // terminal pin control field positions
    localparam int BIT_END_PIN_EN_CH0   = 4;
    localparam int BIT_END_PIN_EN_CH1   = 5;
    // write guard bits: 0 = ch0 a, 1 = ch0 b, 2 = ch1 a, 3 = ch1 b
    localparam logic [7:0]  GUARD_MASK     = 8'h0F;
    localparam logic [7:0]  TERM_MASK      = 8'h30;
    localparam logic [15:0] DTC_LOCK_MASK  = 16'hF000;
    localparam logic [15:0] ARMED_MASK     = 16'h00F0;
    // reset values
    localparam logic [15:0] RST_CHAN_CTRL  = 16'h0000;
    localparam logic [7:0]  RST_GUARD      = 8'h00;
    localparam logic [7:0]  RST_TERM       = 8'h00;
endpackage : dmg_pkg

//--- test/dmg_host_model.sv
// dmg_host_model: cpu or data transfer controller acting as apb master
// assumes a slave on pclk; the bench calls xfer by hierarchical name
`timescale 1ns/10ps
`default_nettype none
module dmg_host_model (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    output logic             dtc_master,
    output logic             hung
);
    // idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hFF;
        pwdata = 32'h0000_0000;
        dtc_master = 1'b0;
        hung = 1'b0;
    end

    // one transfer; request held until pready seen at an edge
    task automatic xfer(input logic data_transfer_controller, input logic wr,
                        input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        dtc_master <= data_transfer_controller;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        hung = (n >= 50); // blocking so the caller sees it on return
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines flip so a stale value is never read as valid
        paddr <= ~a;
        pwdata <= ~wd;
        dtc_master <= 1'b0;
    endtask : xfer
endmodule : dmg_host_model
`default_nettype wire

//--- test/test_dmg_guard.sv
// test_dmg_guard: directed register and pin tests of the dma guard block
// assumes dmg_host_model as bus master and dmg_pkg offsets
`timescale 1ns/10ps
`default_nettype none
module test_dmg_guard;
    logic        pclk, presetn, psel, penable, pwrite, dtc_master;
    logic        pready, pslverr, hung, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [1:0]  xfer_done, block_mode, count_zero_cycle, block_zero_cycle;
    logic [1:0]  chan_active, end_irq_req, break_irq_req;
    logic [1:0]  end_pin, end_pin_oe_n;
    int          failures, total_checks;

    dmg_guard dmg_guard_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dtc_master(dtc_master), .xfer_done(xfer_done),
        .block_mode(block_mode), .count_zero_cycle(count_zero_cycle),
        .block_zero_cycle(block_zero_cycle), .chan_active(chan_active),
        .end_irq_req(end_irq_req), .break_irq_req(break_irq_req),
        .end_pin(end_pin), .end_pin_oe_n(end_pin_oe_n));
    dmg_host_model dmg_host_model_i (.pclk(pclk), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .dtc_master(dtc_master), .hung(hung));

    // 25 mhz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic close_out;
        if (failures == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // bus access; a hang ends the run
    task automatic acc(input logic d, input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        dmg_host_model_i.xfer(d, w, a, wd, rdat, err);
        if (dmg_host_model_i.hung === 1'b1) begin
            failures++;
            $display("[ERR] %0t bus wait ran out", $time);
            close_out();
        end
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b0, 1'b1, a, d);
    endtask : wr

    task automatic dwr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, 1'b1, a, d);
    endtask : dwr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, 1'b0, a, 32'h0000_0000);
        chk(rdat, e);
    endtask : rd_chk

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : tick

    // one zero-cycle pulse, end pin looked at one edge later
    task automatic pulse(input int c, input logic bm, input logic cz,
                         input logic bz, input logic e);
        @(posedge pclk);
        block_mode <= {bm, bm};
        count_zero_cycle <= {1'b0, cz} << c;
        block_zero_cycle <= {1'b0, bz} << c;
        @(posedge pclk);
        count_zero_cycle <= 2'b00;
        block_zero_cycle <= 2'b00;
        #1;
        chk(32'(end_pin[c]), 32'(e));
        tick(1);
        chk(32'(end_pin[c]), 32'h0000_0000);
    endtask : pulse

    // bits 11..0 open where guard bit b mod 4 is set
    function automatic logic [31:0] gmask(input logic [3:0] g);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 12; b++)
            m[b] = g[b % 4];
        return m;
    endfunction : gmask

    // main sequence
    initial begin
        logic [31:0] e, k, x, m;
        logic [3:0]  g;
        presetn = 1'b0;
        xfer_done = 2'b00;
        block_mode = 2'b00;
        count_zero_cycle = 2'b00;
        block_zero_cycle = 2'b00;
        failures = 0;
        total_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        tick(1);
        chk(32'(end_pin_oe_n), 32'h0000_0003);
        for (int i = 0; i < 3; i++)
            rd_chk(8'(4 * i), 32'h0000_0000);
        wr(8'h04, 32'hFFFF_FFFF);
        rd_chk(8'h04, 32'h0000_000F);
        wr(8'h08, 32'hFFFF_FFFF);
        rd_chk(8'h08, 32'h0000_0030);
        tick(1);
        chk(32'(end_pin_oe_n), 32'h0000_0000);
        acc(1'b0, 1'b0, 8'h20, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        acc(1'b0, 1'b1, 8'h01, 32'hFFFF_FFFF);
        chk(32'(err), 32'h0000_0001);
        rd_chk(8'h00, 32'h0000_0000);
        wr(8'h00, 32'h0000_0007);
        rd_chk(8'h00, 32'h0000_0007);
        // end and break requests per channel
        for (int c = 0; c < 2; c++) begin
            e = 32'h0000_0001 << (2 * c);
            k = 32'h0000_0002 << (2 * c);
            x = 32'h0000_0010 << (2 * c);
            m = 32'h0000_0020 << (2 * c);
            wr(8'h00, 32'h0000_0000);
            rd_chk(8'h00, 32'h0000_0000);
            wr(8'h00, e | k | x | m);
            tick(1);
            chk(32'(chan_active), 32'h0000_0001 << c);
            @(posedge pclk);
            xfer_done <= 2'b01 << c;
            @(posedge pclk);
            xfer_done <= 2'b00;
            tick(2);
            chk(32'(end_irq_req[c]), 32'h0000_0001);
            rd_chk(8'h00, e | k | m);
            rd_chk(8'h0C, 32'h0000_0001 << c);
            tick(3);
            chk(32'(end_irq_req[c]), 32'h0000_0001);
            wr(8'h00, (c == 0) ? (k | m) : (e | k | x | m));
            tick(2);
            chk(32'(end_irq_req[c]), 32'h0000_0000);
            wr(8'h00, k);
            tick(2);
            chk(32'(break_irq_req[c]), 32'h0000_0001);
            rd_chk(8'h00, k);
            wr(8'h00, k | m);
            tick(2);
            chk(32'(break_irq_req[c]), 32'h0000_0000);
        end
        // controller writes with each guard bit set alone and with all four set
        for (int i = 0; i < 5; i++) begin
            g = (i == 4) ? 4'hF : 4'(1 << i);
            wr(8'h00, 32'h0000_F000);
            wr(8'h04, 32'(g));
            wr(8'h08, 32'h0000_0000);
            for (int h = 0; h < 4; h++) begin
                wr(8'(16 + 4 * h), 32'h0000_0000);
                dwr(8'(16 + 4 * h), 32'h0000_FFFF);
                rd_chk(8'(16 + 4 * h), g[h] ? 32'h0000_FFFF : 0);
            end
            dwr(8'h00, 32'h0000_0FFF);
            dwr(8'h08, 32'h0000_00FF);
            rd_chk(8'h00, 32'h0000_F000 | gmask(g));
            rd_chk(8'h08, 32'({g[3], g[1]}) << 4);
        end
        wr(8'h00, 32'h0000_0000);
        wr(8'h04, 32'h0000_0000);
        dwr(8'h40, 32'h00AB_CDEF);
        rd_chk(8'h40, 32'h00AB_CDEF);
        dwr(8'h58, 32'h0000_1234);
        rd_chk(8'h58, 32'h0000_1234);
        // end pin in short address mode, both counting modes
        wr(8'h00, 32'h0000_3000);
        wr(8'h08, 32'h0000_0030);
        for (int c = 0; c < 2; c++) begin
            pulse(c, 1'b0, 1'b1, 1'b0, 1'b1);
            pulse(c, 1'b0, 1'b0, 1'b1, 1'b0);
            pulse(c, 1'b1, 1'b0, 1'b1, 1'b1);
            pulse(c, 1'b1, 1'b1, 1'b0, 1'b0);
        end
        wr(8'h00, 32'h0000_F000);
        pulse(0, 1'b1, 1'b1, 1'b1, 1'b0);
        wr(8'h00, 32'h0000_3000);
        wr(8'h08, 32'h0000_0000);
        tick(1);
        chk(32'(end_pin_oe_n), 32'h0000_0003);
        pulse(1, 1'b1, 1'b1, 1'b1, 1'b0);
        close_out();
    end
endmodule : test_dmg_guard
`default_nettype wire
